// ==== design/pst_access.sv ====
// table access controller between the core and the program memory array
`timescale 1ns/100ps
`include "pst_params.svh"
module pst_access (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             clk_en_i,
  // page pointer
  input  wire logic             page_wr_i,
  input  wire logic [7:0]       page_wdata_i,
  output logic      [7:0]       table_page_pointer_o,
  // core table requests
  input  wire logic             req_valid_i,
  output logic                  req_ready_o,
  input  wire pst_pkg::pst_op_t req_op_i,
  input  wire logic             req_byte_i,
  input  wire logic [15:0]      req_ea_i,
  input  wire logic [15:0]      req_wdata_i,
  // core answers
  output logic                  ack_o,
  output logic      [15:0]      rdata_o,
  // program memory array
  output logic                  mem_rd_o,
  output logic                  mem_wr_o,
  output logic      [23:0]      mem_addr_o,
  output logic                  mem_cfg_o,
  output logic      [23:0]      mem_wdata_o,
  output logic      [2:0]       mem_wmask_o,
  input  wire logic [23:0]      mem_rdata_i
);
  import pst_pkg::*;

  pst_state_t  state_ff;
  pst_state_t  nxt_state;
  pst_op_t     op_ff;
  logic        byte_ff;
  logic        bsel_ff;
  logic [7:0]  page_ff;
  logic        accept;
  logic        is_write;
  logic [23:0] nxt_addr;
  pst_fmt_if   fmt_bus ();

  //////////////////////////////////////////////////////////////////////////////
  // lane formatter
  pst_fmt u_fmt (
    .f (fmt_bus.fmt)
  );

  // inputs steer the lanes while idle, the held request afterwards
  assign fmt_bus.op        = (state_ff == PST_ST_IDLE) ? req_op_i : op_ff;
  assign fmt_bus.byte_mode = (state_ff == PST_ST_IDLE) ? req_byte_i : byte_ff;
  assign fmt_bus.byte_sel  = (state_ff == PST_ST_IDLE) ? req_ea_i[`PST_BSEL_BIT] : bsel_ff;
  assign fmt_bus.prog_word = mem_rdata_i;
  assign fmt_bus.wr_data   = req_wdata_i;

  //////////////////////////////////////////////////////////////////////////////
  // page pointer
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      page_ff <= `PST_PAGE_RST;
    end else if (clk_en_i && page_wr_i) begin
      page_ff <= page_wdata_i;
    end
  end
  assign table_page_pointer_o = page_ff;

  //////////////////////////////////////////////////////////////////////////////
  // request sequencing
  assign req_ready_o = (state_ff == PST_ST_IDLE);
  assign accept      = clk_en_i && req_valid_i && req_ready_o;
  assign is_write    = (op_ff == PST_OP_WRITE_LOW) || (op_ff == PST_OP_WRITE_HIGH);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PST_ST_IDLE: begin
        if (accept) begin
          nxt_state = PST_ST_ISSUE;
        end
      end
      PST_ST_ISSUE: begin
        nxt_state = is_write ? PST_ST_IDLE : PST_ST_WAIT;
      end
      PST_ST_WAIT: begin
        nxt_state = PST_ST_IDLE;
      end
      default: begin
        nxt_state = PST_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= PST_ST_IDLE;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      op_ff   <= PST_OP_READ_LOW;
      byte_ff <= 1'b0;
      bsel_ff <= 1'b0;
    end else if (accept) begin
      op_ff   <= req_op_i;
      byte_ff <= req_byte_i;
      bsel_ff <= req_ea_i[`PST_BSEL_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // program memory strobes
  // the byte select bit never reaches the array: words sit on even addresses
  assign nxt_addr = {page_ff, req_ea_i[15:1], 1'b0};

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
    end else if (clk_en_i) begin
      mem_rd_o <= accept && !req_op_i[1];
      mem_wr_o <= accept && req_op_i[1];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_addr_o  <= `PST_ADDR_RST;
      mem_cfg_o   <= 1'b0;
      mem_wdata_o <= `PST_ADDR_RST;
      mem_wmask_o <= `PST_MASK_NONE;
    end else if (accept) begin
      mem_addr_o  <= nxt_addr;
      mem_cfg_o   <= page_ff[`PST_CFG_BIT];
      mem_wdata_o <= fmt_bus.wr_word;
      mem_wmask_o <= req_op_i[1] ? fmt_bus.wr_mask : `PST_MASK_NONE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // answers to the core
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_o <= 1'b0;
    end else if (clk_en_i) begin
      ack_o <= (state_ff == PST_ST_WAIT) || (state_ff == PST_ST_ISSUE && is_write);
    end
  end

  // last read data stays visible until the next read finishes
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= `PST_DATA_RST;
    end else if (clk_en_i && state_ff == PST_ST_WAIT) begin
      rdata_o <= fmt_bus.rd_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  logic [7:0] pw_hi;
  logic [7:0] pw_mid;
  logic [7:0] pw_lo;
  logic       wait_go;
  assign pw_hi   = mem_rdata_i[23:16];
  assign pw_mid  = mem_rdata_i[15:8];
  assign pw_lo   = mem_rdata_i[7:0];
  assign wait_go = clk_en_i && (state_ff == PST_ST_WAIT);
  logic       page_cfg;
  logic       req_bsel;
  logic [7:0] req_wbyte;
  assign page_cfg  = page_ff[`PST_CFG_BIT];
  assign req_bsel  = req_ea_i[`PST_BSEL_BIT];
  assign req_wbyte = req_wdata_i[7:0];

  AST_LOW_WORD_READ: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wait_go && op_ff == PST_OP_READ_LOW && !byte_ff
    |=> ack_o && rdata_o == {$past(pw_mid), $past(pw_lo)})
    else $error("low word read lost program bits");

  AST_LOW_BYTE_READ: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wait_go && op_ff == PST_OP_READ_LOW && byte_ff
    |=> rdata_o == {`PST_ZERO_BYTE, ($past(bsel_ff) ? $past(pw_mid) : $past(pw_lo))})
    else $error("low byte read picked wrong byte");

  AST_HIGH_WORD_READ: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wait_go && op_ff == PST_OP_READ_HIGH && !byte_ff
    |=> rdata_o == {`PST_ZERO_BYTE, $past(pw_hi)})
    else $error("high word read phantom byte not zero");

  AST_HIGH_BYTE_READ: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wait_go && op_ff == PST_OP_READ_HIGH && byte_ff
    |=> rdata_o == ($past(bsel_ff) ? `PST_DATA_RST : {`PST_ZERO_BYTE, $past(pw_hi)}))
    else $error("high byte read wrong value");

  AST_UPPER_ONLY_HIGH: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    mem_wr_o && mem_wmask_o[2] |-> op_ff == PST_OP_WRITE_HIGH && mem_wmask_o[1:0] == 2'h0)
    else $error("upper byte written by a low operation");

  AST_LOW_SPACE_WRITE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    mem_wr_o && op_ff == PST_OP_WRITE_LOW |-> !mem_wmask_o[2] && mem_wmask_o != `PST_MASK_NONE)
    else $error("low write outside the low word space");

  AST_EVEN_ADDRESS: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (mem_rd_o || mem_wr_o) |-> !mem_addr_o[0])
    else $error("program address not on a word boundary");

  AST_PAGE_ADDRESS: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept |=> mem_addr_o[23:16] == $past(page_ff)
      && {mem_addr_o[15:1], 1'b0} == ($past(req_ea_i) & 16'hFFFE))
    else $error("program address not formed from page and offset");

  AST_CFG_SPACE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (mem_rd_o || mem_wr_o) |-> mem_cfg_o == mem_addr_o[`PST_ADDR_CFG_BIT])
    else $error("space select disagrees with page bit 7");

  AST_WRITE_SEQ: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && req_op_i[1] |=> mem_wr_o && !mem_rd_o ##1 (!$past(clk_en_i) || ack_o))
    else $error("table write not issued and answered");

  AST_READ_SEQ: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && !req_op_i[1] |=> mem_rd_o && !mem_wr_o && !req_ready_o)
    else $error("table read not issued to program memory");

  //////////////////////////////////////////////////////////////////////////////
  // write lanes, page pointer and handshake timing

  AST_LOW_WORD_WRITE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && req_op_i == PST_OP_WRITE_LOW && !req_byte_i
    |=> mem_wmask_o == `PST_MASK_WORD && mem_wdata_o[15:0] == $past(req_wdata_i))
    else $error("low word write lost data bits");

  AST_LOW_BYTE_WRITE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && req_op_i == PST_OP_WRITE_LOW && req_byte_i
    |=> mem_wmask_o == ($past(req_bsel) ? `PST_MASK_MID : `PST_MASK_LO))
    else $error("low byte write hit the wrong lane");

  AST_LOW_BYTE_DATA: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && req_op_i == PST_OP_WRITE_LOW && req_byte_i
    |=> ($past(req_bsel) ? mem_wdata_o[15:8] : mem_wdata_o[7:0]) == $past(req_wbyte))
    else $error("low byte write carried the wrong byte");

  AST_HIGH_WR_DATA: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && req_op_i == PST_OP_WRITE_HIGH
    |=> mem_wdata_o[23:16] == $past(req_wbyte))
    else $error("high write carried the wrong byte");

  AST_HIGH_WR_LANE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && req_op_i == PST_OP_WRITE_HIGH && !(req_byte_i && req_bsel)
    |=> mem_wmask_o == `PST_MASK_HI)
    else $error("high write missed the upper lane");

  AST_PHANTOM_WRITE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && req_op_i == PST_OP_WRITE_HIGH && req_byte_i && req_bsel
    |=> mem_wr_o && mem_wmask_o == `PST_MASK_NONE)
    else $error("phantom byte write reached program memory");

  AST_ONE_STROBE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    mem_rd_o || mem_wr_o
    |-> !(mem_rd_o && mem_wr_o))
    else $error("read and write strobes together");

  AST_STROBE_PULSE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    clk_en_i && (mem_rd_o || mem_wr_o)
    |=> !mem_rd_o && !mem_wr_o)
    else $error("program memory strobe stood too long");

  AST_PAGE_SPACE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept
    |=> mem_cfg_o == $past(page_cfg))
    else $error("space select not taken from the page pointer");

  AST_PAGE_LOAD: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    clk_en_i && page_wr_i
    |=> table_page_pointer_o == $past(page_wdata_i))
    else $error("page pointer write lost");

  AST_PAGE_HOLD: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !(clk_en_i && page_wr_i)
    |=> $stable(table_page_pointer_o))
    else $error("page pointer changed without a write");

  AST_ACK_PULSE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    clk_en_i && ack_o
    |=> !ack_o)
    else $error("answer stood longer than one cycle");

  AST_RDATA_HOLD: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !wait_go
    |=> $stable(rdata_o))
    else $error("read data changed without a finished read");

  AST_READY_AT_ACK: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    ack_o
    |-> req_ready_o)
    else $error("controller busy while answering");

  AST_READ_ANSWER: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && !req_op_i[1] ##1 clk_en_i ##1 clk_en_i
    |=> ack_o)
    else $error("table read not answered on the third cycle");

endmodule : pst_access

// ==== design/pst_params.svh ====
// constants for the program space table access path
`ifndef PST_PARAMS_SVH
`define PST_PARAMS_SVH

// reset values
`define PST_PAGE_RST       8'h00
`define PST_DATA_RST       16'h0000
`define PST_ADDR_RST       24'h00_0000
`define PST_MASK_NONE      3'h0

// field positions inside the page pointer, a program address and an effective address
`define PST_CFG_BIT        7
`define PST_ADDR_CFG_BIT   23
`define PST_BSEL_BIT       0

// byte lane masks of a program word: bit0 low, bit1 mid, bit2 upper
`define PST_MASK_LO        3'h1
`define PST_MASK_MID       3'h2
`define PST_MASK_HI        3'h4
`define PST_MASK_WORD      3'h3

// zero fill for the phantom byte
`define PST_ZERO_BYTE      8'h00

`endif

// ==== design/pst_pkg.sv ====
// types shared by the table access modules
package pst_pkg;

  typedef enum logic [1:0] {
    PST_OP_READ_LOW   = 2'b00,
    PST_OP_READ_HIGH  = 2'b01,
    PST_OP_WRITE_LOW  = 2'b10,
    PST_OP_WRITE_HIGH = 2'b11
  } pst_op_t;

  typedef enum logic [1:0] {
    PST_ST_IDLE  = 2'b00,
    PST_ST_ISSUE = 2'b01,
    PST_ST_WAIT  = 2'b10
  } pst_state_t;

endpackage : pst_pkg

// ==== design/pst_fmt_if.sv ====
// lane steering signals between the access controller and the formatter
`timescale 1ns/100ps
interface pst_fmt_if;
  pst_pkg::pst_op_t op;
  logic             byte_mode;
  logic             byte_sel;
  logic [23:0]      prog_word;
  logic [15:0]      wr_data;
  logic [15:0]      rd_data;
  logic [23:0]      wr_word;
  logic [2:0]       wr_mask;

  modport ctl (output op, byte_mode, byte_sel, prog_word, wr_data,
               input  rd_data, wr_word, wr_mask);
  modport fmt (input  op, byte_mode, byte_sel, prog_word, wr_data,
               output rd_data, wr_word, wr_mask);
endinterface : pst_fmt_if

// ==== design/pst_fmt.sv ====
// byte lane steering between 24-bit program words and 16-bit data
`timescale 1ns/100ps
`include "pst_params.svh"
module pst_fmt (
  pst_fmt_if.fmt f
);
  import pst_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // read side
  always_comb begin
    f.rd_data = `PST_DATA_RST;
    unique case (f.op)
      PST_OP_READ_LOW: begin
        if (!f.byte_mode) begin
          f.rd_data = f.prog_word[15:0];
        end else if (f.byte_sel) begin
          f.rd_data = {`PST_ZERO_BYTE, f.prog_word[15:8]};
        end else begin
          f.rd_data = {`PST_ZERO_BYTE, f.prog_word[7:0]};
        end
      end
      PST_OP_READ_HIGH: begin
        // phantom byte never carries program data
        if (!f.byte_mode) begin
          f.rd_data = {`PST_ZERO_BYTE, f.prog_word[23:16]};
        end else if (f.byte_sel) begin
          f.rd_data = `PST_DATA_RST;
        end else begin
          f.rd_data = {`PST_ZERO_BYTE, f.prog_word[23:16]};
        end
      end
      PST_OP_WRITE_LOW, PST_OP_WRITE_HIGH: begin
        f.rd_data = `PST_DATA_RST;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // write side
  always_comb begin
    f.wr_word = `PST_ADDR_RST;
    f.wr_mask = `PST_MASK_NONE;
    unique case (f.op)
      PST_OP_WRITE_LOW: begin
        if (!f.byte_mode) begin
          f.wr_word = {`PST_ZERO_BYTE, f.wr_data};
          f.wr_mask = `PST_MASK_WORD;
        end else if (f.byte_sel) begin
          f.wr_word = {`PST_ZERO_BYTE, f.wr_data[7:0], `PST_ZERO_BYTE};
          f.wr_mask = `PST_MASK_MID;
        end else begin
          f.wr_word = {`PST_ZERO_BYTE, `PST_ZERO_BYTE, f.wr_data[7:0]};
          f.wr_mask = `PST_MASK_LO;
        end
      end
      PST_OP_WRITE_HIGH: begin
        // a write to the phantom byte is dropped: there is no storage behind it
        f.wr_word = {f.wr_data[7:0], `PST_ZERO_BYTE, `PST_ZERO_BYTE};
        if (f.byte_mode && f.byte_sel) begin
          f.wr_mask = `PST_MASK_NONE;
        end else begin
          f.wr_mask = `PST_MASK_HI;
        end
      end
      PST_OP_READ_LOW, PST_OP_READ_HIGH: begin
        f.wr_mask = `PST_MASK_NONE;
      end
    endcase
  end

endmodule : pst_fmt

// ==== tb/pst_mem_model.sv ====
// program memory array model answering one cycle after a read strobe
`timescale 1ns/100ps
module pst_mem_model (
  // clock
  input  wire logic        sys_clk_i,
  // access from the table path
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic [23:0] mem_addr_i,
  input  wire logic        mem_cfg_i,
  input  wire logic [23:0] mem_wdata_i,
  input  wire logic [2:0]  mem_wmask_i,
  // read data
  output logic      [23:0] mem_rdata_o
);
  logic [23:0] mem [logic [24:0]];
  logic [24:0] key;
  logic [23:0] w;

  assign key = {mem_cfg_i, mem_addr_i};

  initial mem_rdata_o = 24'h00_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // user and configuration words are kept apart by the space bit
  always @(posedge sys_clk_i) begin
    if (mem_rd_i || mem_wr_i) begin
      w = mem.exists(key) ? mem[key] : 24'h5a_5a5a;
      for (int i = 0; i < 3; i++) begin
        if (mem_wr_i && mem_wmask_i[i]) w[8*i +: 8] = mem_wdata_i[8*i +: 8];
      end
      mem[key] = w;
    end
    // outside the answer cycle the data is not to be trusted, so it toggles
    mem_rdata_o <= mem_rd_i ? w : ~mem_rdata_o;
  end
endmodule : pst_mem_model

// ==== tb/program_space_table_access_tb_top.sv ====
// self-checking bench for the table access controller
`timescale 1ns/100ps
module program_space_table_access_tb_top;
  import pst_pkg::*;
  typedef struct {
    logic [7:0]  pg;
    pst_op_t     op;
    logic        bt;
    logic [15:0] ea;
    logic [15:0] wd;
    logic [15:0] ex;
  } pst_row_t;

  logic sys_clk_i = 0, resetn_i = 0, clk_en_i = 1, page_wr_i = 0, req_valid_i = 0;
  logic req_byte_i = 0, req_ready_o, ack_o, mem_rd_o, mem_wr_o, mem_cfg_o;
  logic [7:0] page_wdata_i = 8'h00, table_page_pointer_o;
  pst_op_t req_op_i = PST_OP_READ_LOW;
  logic [15:0] req_ea_i = 16'h0000, req_wdata_i = 16'h0000, rdata_o;
  logic [23:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
  logic [2:0] mem_wmask_o;
  int bad_count = 0, check_count = 0, cyc = 0;
  pst_row_t rows [16];

  pst_access DUT (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
    .page_wr_i(page_wr_i), .page_wdata_i(page_wdata_i),
    .table_page_pointer_o(table_page_pointer_o), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_op_i(req_op_i), .req_byte_i(req_byte_i),
    .req_ea_i(req_ea_i), .req_wdata_i(req_wdata_i), .ack_o(ack_o), .rdata_o(rdata_o),
    .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
    .mem_cfg_o(mem_cfg_o), .mem_wdata_o(mem_wdata_o), .mem_wmask_o(mem_wmask_o),
    .mem_rdata_i(mem_rdata_i));
  pst_mem_model MEM (.sys_clk_i(sys_clk_i), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
    .mem_addr_i(mem_addr_o), .mem_cfg_i(mem_cfg_o), .mem_wdata_i(mem_wdata_o),
    .mem_wmask_i(mem_wmask_o), .mem_rdata_o(mem_rdata_i));

  always #2.5 sys_clk_i = ~sys_clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  // a cut short run counts as a mismatch; 5000 cycles is far above the planned ~80
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // entered and left at 1 ns after a rising edge; request held until taken
  task automatic do_op(input pst_row_t r);
    int n;
    logic rd;
    logic [23:0] lm, ew;
    rd = (r.op == PST_OP_READ_LOW || r.op == PST_OP_READ_HIGH);
    lm = {{8{r.ex[2]}}, {8{r.ex[1]}}, {8{r.ex[0]}}};
    ew = (r.op == PST_OP_WRITE_HIGH) ? {r.wd[7:0], 16'h0000} :
         !r.bt ? {8'h00, r.wd} : r.ea[0] ? {8'h00, r.wd[7:0], 8'h00} : {16'h0000, r.wd[7:0]};
    req_valid_i = 1;
    req_op_i = r.op;
    req_byte_i = r.bt;
    req_ea_i = r.ea;
    req_wdata_i = r.wd;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 20) begin
      @(posedge sys_clk_i) #1;
      n++;
    end
    @(posedge sys_clk_i) #1;
    req_valid_i = 0;
    check(24'(mem_rd_o), 24'(rd), "read strobe");
    check(24'(mem_wr_o), 24'(!rd), "write strobe");
    check(mem_addr_o, {r.pg, r.ea[15:1], 1'b0}, "address");
    check(24'(mem_cfg_o), 24'(r.pg[7]), "space");
    if (!rd) check({21'h0, mem_wmask_o}, {8'h00, r.ex}, "lane mask");
    if (!rd) check(mem_wdata_o & lm, ew & lm, "write lanes");
    n = 1;
    while (ack_o !== 1'b1 && n < 10) begin
      @(posedge sys_clk_i) #1;
      n++;
    end
    check(24'(n), rd ? 24'h00_0003 : 24'h00_0002, "latency");
    check(24'(req_ready_o), 24'h00_0001, "ready at answer");
    if (rd) check(24'(rdata_o), 24'(r.ex), "read data");
  endtask : do_op

  task automatic set_page(input logic [7:0] v);
    page_wr_i = 1;
    page_wdata_i = v;
    @(posedge sys_clk_i) #1;
    page_wr_i = 0;
    check(24'(table_page_pointer_o), 24'(v), "page pointer");
  endtask : set_page

  // outputs are looked at only after clock edges in reset: the flops start unknown
  task automatic reset_check;
    resetn_i = 0;
    repeat (10) @(posedge sys_clk_i);
    #1;
    check(24'(table_page_pointer_o), 24'h00_0000, "page at reset");
    check({req_ready_o, ack_o, mem_rd_o, mem_wr_o}, 24'h00_0008, "strobes at reset");
    resetn_i = 1;
  endtask : reset_check

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{
      '{8'h00, PST_OP_WRITE_LOW,  0, 16'h0010, 16'hbeef, 16'h0003},
      '{8'h00, PST_OP_WRITE_HIGH, 0, 16'h0010, 16'h12a5, 16'h0004},
      '{8'h00, PST_OP_READ_LOW,   0, 16'h0010, 16'h0000, 16'hbeef},
      '{8'h00, PST_OP_READ_LOW,   1, 16'h0011, 16'h0000, 16'h00be},
      '{8'h00, PST_OP_READ_LOW,   1, 16'h0010, 16'h0000, 16'h00ef},
      '{8'h00, PST_OP_READ_HIGH,  0, 16'h0010, 16'h0000, 16'h00a5},
      '{8'h00, PST_OP_READ_HIGH,  1, 16'h0010, 16'h0000, 16'h00a5},
      '{8'h00, PST_OP_READ_HIGH,  1, 16'h0011, 16'h0000, 16'h0000},
      '{8'h00, PST_OP_WRITE_LOW,  1, 16'h0013, 16'h0077, 16'h0002},
      '{8'h00, PST_OP_WRITE_LOW,  1, 16'h0012, 16'h0066, 16'h0001},
      '{8'h00, PST_OP_WRITE_HIGH, 1, 16'h0012, 16'h0099, 16'h0004},
      '{8'h00, PST_OP_WRITE_HIGH, 1, 16'h0011, 16'h00c3, 16'h0000},
      '{8'h00, PST_OP_READ_LOW,   0, 16'h0012, 16'h0000, 16'h7766},
      '{8'h00, PST_OP_READ_HIGH,  0, 16'h0012, 16'h0000, 16'h0099},
      '{8'h80, PST_OP_WRITE_LOW,  0, 16'hfffe, 16'h1357, 16'h0003},
      '{8'h80, PST_OP_READ_LOW,   0, 16'hffff, 16'h0000, 16'h1357}};
    reset_check();
    @(posedge sys_clk_i) #1;
    foreach (rows[i]) begin
      if (table_page_pointer_o !== rows[i].pg) set_page(rows[i].pg);
      do_op(rows[i]);
    end
    // phantom byte write must leave the upper byte alone; other space, other page
    do_op('{8'h80, PST_OP_READ_LOW, 0, 16'h0010, 16'h0000, 16'h5a5a});
    set_page(8'h00);
    do_op('{8'h00, PST_OP_READ_HIGH, 0, 16'h0010, 16'h0000, 16'h00a5});
    // a frozen clock enable must hold the page pointer
    clk_en_i = 0;
    page_wr_i = 1;
    page_wdata_i = 8'h55;
    repeat (2) @(posedge sys_clk_i) #1;
    check(24'(table_page_pointer_o), 24'h00_0000, "frozen page");
    page_wr_i = 0;
    clk_en_i = 1;
    // page write in the taking edge: request still uses the old page
    page_wr_i = 1;
    page_wdata_i = 8'h80;
    do_op('{8'h00, PST_OP_READ_LOW, 0, 16'h0010, 16'h0000, 16'hbeef});
    page_wr_i = 0;
    check(24'(table_page_pointer_o), 24'h00_0080, "page after");
    do_op('{8'h80, PST_OP_READ_LOW, 0, 16'hfffe, 16'h0000, 16'h1357});
    // reset in mid-run clears the page back to user space
    reset_check();
    @(posedge sys_clk_i) #1;
    do_op('{8'h00, PST_OP_READ_LOW, 0, 16'h0010, 16'h0000, 16'hbeef});
    results();
  end
endmodule : program_space_table_access_tb_top
